// file: hdl/swire_pkg.sv
/*
 Constants, types and timing for the single-wire EEPROM command layer.
 Assumes a 250 MHz system clock; times are kept in ns and turned into cycles.
*/
package swire_pkg;
   // --------------------------------------------------------------
   // Clock and line timing
   // --------------------------------------------------------------
   localparam int CLK_PERIOD_NS   = 4;
   localparam int T_SAMPLE_STD_NS = 30000;   // Sample point after the falling edge
   localparam int T_SAMPLE_OD_NS  = 3000;
   localparam int T_RST_STD_NS    = 120000;  // Low longer than this is a reset
   localparam int T_RST_OD_NS     = 16000;
   localparam int T_RST_LONG_NS   = 480000;  // Reset that restores standard speed
   localparam int T_PDH_STD_NS    = 15000;   // Wait before presence
   localparam int T_PDH_OD_NS     = 2000;
   localparam int T_PDL_STD_NS    = 120000;  // Presence low time
   localparam int T_PDL_OD_NS     = 12000;

   // Least time to whole cycles, never below one
   function automatic int ns_to_cyc(input int ns);
      int c;
      c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction

   localparam int SAMPLE_OD_CYC = ns_to_cyc(T_SAMPLE_OD_NS);
   localparam int RST_OD_CYC    = ns_to_cyc(T_RST_OD_NS);
   localparam int PDH_STD_CYC   = ns_to_cyc(T_PDH_STD_NS);
   localparam int PDH_OD_CYC    = ns_to_cyc(T_PDH_OD_NS);
   localparam int PDL_OD_CYC    = ns_to_cyc(T_PDL_OD_NS);
   localparam int CNT_W         = 18;

   // --------------------------------------------------------------
   // Command codes, memory layout, CRC
   // --------------------------------------------------------------
   localparam logic [7:0]  CMD_READ_ID    = 8'h33;
   localparam logic [7:0]  CMD_MATCH_ID   = 8'h55;
   localparam logic [7:0]  CMD_SEARCH_ID  = 8'hF0;
   localparam logic [7:0]  CMD_SKIP_ID    = 8'hCC;
   localparam logic [7:0]  CMD_RESUME     = 8'hA5;
   localparam logic [7:0]  CMD_FAST_SKIP  = 8'h3C;
   localparam logic [7:0]  CMD_FAST_MATCH = 8'h69;
   localparam logic [7:0]  CMD_READ_MEM   = 8'hF0;
   localparam logic [7:0]  CMD_READ_EXT   = 8'hA5;
   localparam logic [15:0] MEM_LAST_ADDR  = 16'h0A3F;
   localparam logic [15:0] ADDR_WRAP_MASK = 16'h0FFF;
   localparam int          MEM_BYTES      = 2624;
   localparam logic [4:0]  PAGE_LAST_OFS  = 5'h1F;
   localparam logic [7:0]  FILL_BYTE      = 8'hFF;
   localparam logic [15:0] CRC16_POLY_REV = 16'hA001;  // x16+x15+x2+1, shifted right
   localparam logic [6:0]  ID_LAST_BIT    = 7'h3F;

   typedef enum logic [9:0] {
      P_IDLE    = 10'b0000000001,
      P_ROM_CMD = 10'b0000000010,
      P_ROM_TX  = 10'b0000000100,
      P_MATCH   = 10'b0000001000,
      P_SRCH_T  = 10'b0000010000,
      P_SRCH_C  = 10'b0000100000,
      P_SRCH_R  = 10'b0001000000,
      P_MEM_CMD = 10'b0010000000,
      P_ADDR    = 10'b0100000000,
      P_DATA    = 10'b1000000000
   } proto_state_t;

   // One buffered item headed for the line
   typedef struct packed {
      logic       is_crc;
      logic [7:0] data;
   } tx_entry_t;
endpackage

// file: hdl/swire_eeprom_cmd.sv
/*
 Slave command layer of a single-wire EEPROM: reset and presence, identity
 commands, plain and extended memory reads with page CRC.
 Assumes the line is open drain with an external pull-up; the pad resolves
 dq_oe_n low as a pull to ground. Memory contents are loaded on the user side.
*/
// Function
// R1: F0h reads memory from two-byte address
// R2: Address above 0A3Fh loses upper four bits
// R3: Past 0A3Fh plain read returns FFh
// R4: Memory reads set bad-sequence flag, reset ends
// R5: A5h read appends inverted CRC16 per page
// R6: Next page follows CRC, FFh past end
// R7: CRC16 x16+x15+x2+1, cleared before stream
// R8: Bad-sequence flag blocks copy authorization
// R9: Master keeps line high when suspending
// R10: Init, identity command, memory command, data
// R11: Reset pulse answered by presence pulse
// R12: Seven eight-bit identity commands accepted
// R13: 33h sends 64-bit identity
// R14: 55h compares 64 bits, mismatch waits reset
// R15: F0h search: bit, complement, master bit
// R16: CCh goes straight to memory commands
// R17: A5h proceeds only with resume flag
// R18: Resume flag set by successful addressing
// R19: Resume flag cleared when deselected
// R20: 3Ch sets fast speed until long reset
// R21: Master re-addresses after fast skip
// R22: Line driven only by open-drain pull-down
// R23: Slot timing starts at master falling edge
// R24: 69h matches identity, sets fast speed
// R25: Bits LSB first, address low byte first
// R26: Unknown command ignored until next reset
`timescale 1ns/1ps
module swire_eeprom_cmd
   import swire_pkg::*;
#(
   parameter logic [63:0] DEVICE_ID      = 64'h5A3C_9E17_0B62_D4A1,  // Arbitrary value
   parameter int          SAMPLE_STD_CYC = ns_to_cyc(T_SAMPLE_STD_NS),
   parameter int          RST_STD_CYC    = ns_to_cyc(T_RST_STD_NS),
   parameter int          RST_LONG_CYC   = ns_to_cyc(T_RST_LONG_NS),
   parameter int          PDL_STD_CYC    = ns_to_cyc(T_PDL_STD_NS)
) (
   input  wire logic        sys_clk,
   input  wire logic        sys_rst,
   input  wire logic        dq_in,
   output logic             dq_out,
   output logic             dq_oe_n,
   input  wire logic        mem_wr_en,
   input  wire logic [11:0] mem_wr_addr,
   input  wire logic [7:0]  mem_wr_data,
   input  wire logic        scratch_written,
   input  wire logic        copy_req,
   output logic             copy_authorized,
   output logic             bad_sequence_flag,
   output logic             resume_enable_flag,
   output logic             fast_speed_flag
);
   // --------------------------------------------------------------
   // Declarations
   // --------------------------------------------------------------
   logic [7:0]       mem [0:MEM_BYTES-1];
   logic             dq_s1, dq_s2, dq_prev, fall, rise;
   logic [CNT_W-1:0] low_cnt, pres_cnt, sample_thr, rst_thr, pdh_thr, pdl_thr;
   logic             pres_wait, pres_drive, pres_busy, slot_open;
   logic             bit_evt, bit_val, reset_evt, long_rst;
   proto_state_t     state;
   logic [6:0]       bit_cnt;
   logic [7:0]       shreg, next_byte;
   logic [15:0]      addr_sh, next_addr, crc;
   logic             ext_mode, fast_cmd, fast_saved;
   logic             tx_mode, tx_bit, rom_done, mem_done, addr_done, mem_read_start;
   tx_entry_t        fifo [0:1];
   tx_entry_t        push_entry;
   logic             wr_ptr, rd_ptr, push, pop, push_ready;
   logic [1:0]       fifo_cnt;
   logic [11:0]      fetch_addr;
   logic             past_end, crc_pending;
   logic [15:0]      tx_sh;
   logic [4:0]       tx_left;
   logic             tx_is_crc;

   assign dq_out = 1'b0;  // R22

   // Speed-dependent thresholds
   always_comb begin
      sample_thr = fast_speed_flag ? CNT_W'(SAMPLE_OD_CYC) : CNT_W'(SAMPLE_STD_CYC);
      rst_thr    = fast_speed_flag ? CNT_W'(RST_OD_CYC)    : CNT_W'(RST_STD_CYC);
      pdh_thr    = fast_speed_flag ? CNT_W'(PDH_OD_CYC)    : CNT_W'(PDH_STD_CYC);
      pdl_thr    = fast_speed_flag ? CNT_W'(PDL_OD_CYC)    : CNT_W'(PDL_STD_CYC);
   end

   // --------------------------------------------------------------
   // Line front end
   // --------------------------------------------------------------
   // Two-stage synchroniser and edge history
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         dq_s1   <= 1'b1;
         dq_s2   <= 1'b1;
         dq_prev <= 1'b1;
      end else begin
         dq_s1   <= dq_in;
         dq_s2   <= dq_s1;
         dq_prev <= dq_s2;
      end
   end
   assign fall      = dq_prev & ~dq_s2;
   assign rise      = ~dq_prev & dq_s2;
   assign pres_busy = pres_wait | pres_drive;

   // Time since slot start, reset pulse detection
   // Counts on while high so write-one slots still reach the sample point;
   // falls inside an open slot (own pull-down echo) do not restart it
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         low_cnt   <= '0;
         reset_evt <= 1'b0;
         long_rst  <= 1'b0;
      end else begin
         reset_evt <= rise && !pres_busy &&
                      (low_cnt >= rst_thr || low_cnt >= CNT_W'(RST_LONG_CYC));  // R11
         long_rst  <= rise && !pres_busy && (low_cnt >= CNT_W'(RST_LONG_CYC));  // R20
         if (pres_busy)
            low_cnt <= '0;
         else if (fall && !slot_open)
            low_cnt <= CNT_W'(1);
         else if (low_cnt != '1)
            low_cnt <= low_cnt + CNT_W'(1);
      end
   end

   // Presence: wait, then pull low
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pres_wait  <= 1'b0;
         pres_drive <= 1'b0;
         pres_cnt   <= '0;
      end else if (reset_evt) begin
         pres_wait <= 1'b1;  // R11
         pres_cnt  <= '0;
      end else if (pres_wait) begin
         pres_cnt <= pres_cnt + CNT_W'(1);
         if (pres_cnt >= pdh_thr) begin
            pres_wait  <= 1'b0;
            pres_drive <= 1'b1;
            pres_cnt   <= '0;
         end
      end else if (pres_drive) begin
         pres_cnt <= pres_cnt + CNT_W'(1);
         if (pres_cnt >= pdl_thr)
            pres_drive <= 1'b0;
      end
   end

   // Slot engine: one bit per master falling edge
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         slot_open <= 1'b0;
         bit_evt   <= 1'b0;
         bit_val   <= 1'b1;
      end else begin
         bit_evt <= 1'b0;
         if (reset_evt || pres_busy)
            slot_open <= 1'b0;
         else if (fall && !slot_open)
            slot_open <= 1'b1;  // R23
         else if (slot_open && low_cnt >= sample_thr) begin
            slot_open <= 1'b0;
            bit_evt   <= 1'b1;
            bit_val   <= tx_mode ? tx_bit : dq_s2;
         end
      end
   end

   // Open-drain pull-down for presence and read zeros, held to sample point
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst)
         dq_oe_n <= 1'b1;
      else
         dq_oe_n <= !(pres_drive || (slot_open && tx_mode && !tx_bit &&
                                     low_cnt < sample_thr));  // R22
   end

   // --------------------------------------------------------------
   // Command sequencing
   // --------------------------------------------------------------
   assign next_byte      = {bit_val, shreg[7:1]};  // R25
   assign next_addr      = {bit_val, addr_sh[15:1]};  // R25
   assign rom_done       = bit_evt && state == P_ROM_CMD && bit_cnt == 7'd7;
   assign mem_done       = bit_evt && state == P_MEM_CMD && bit_cnt == 7'd7;
   assign addr_done      = bit_evt && state == P_ADDR && bit_cnt == 7'd15;
   assign mem_read_start = mem_done && (next_byte == CMD_READ_MEM || next_byte == CMD_READ_EXT);

   // Bit to put on the line in sending states
   always_comb begin
      tx_mode = 1'b1;
      tx_bit  = 1'b1;
      case (state)
         P_ROM_TX, P_SRCH_T : tx_bit = DEVICE_ID[bit_cnt[5:0]];  // R13 R15
         P_SRCH_C           : tx_bit = ~DEVICE_ID[bit_cnt[5:0]];  // R15
         P_DATA             : tx_bit = (tx_left != 5'd0) ? tx_sh[0] : 1'b1;
         default            : tx_mode = 1'b0;
      endcase
   end

   // Protocol state machine
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state              <= P_IDLE;
         bit_cnt            <= '0;
         shreg              <= '0;
         addr_sh            <= '0;
         ext_mode           <= 1'b0;
         fast_cmd           <= 1'b0;
         fast_saved         <= 1'b0;
         resume_enable_flag <= 1'b0;
         fast_speed_flag    <= 1'b0;
      end else if (reset_evt) begin
         state   <= P_ROM_CMD;  // R10 R4
         bit_cnt <= '0;
         if (long_rst)
            fast_speed_flag <= 1'b0;  // R20
      end else if (bit_evt) begin
         bit_cnt <= bit_cnt + 7'd1;
         case (state)
            P_ROM_CMD : begin
               shreg <= next_byte;
               if (bit_cnt == 7'd7) begin
                  bit_cnt  <= '0;
                  fast_cmd <= 1'b0;
                  case (next_byte)  // R12
                     CMD_READ_ID    : state <= P_ROM_TX;  // R13
                     CMD_MATCH_ID   : state <= P_MATCH;  // R14
                     CMD_SEARCH_ID  : state <= P_SRCH_T;  // R15
                     CMD_SKIP_ID    : state <= P_MEM_CMD;  // R16
                     CMD_RESUME     : state <= resume_enable_flag ? P_MEM_CMD : P_IDLE;  // R17
                     CMD_FAST_SKIP  : begin
                        fast_speed_flag <= 1'b1;  // R20
                        state           <= P_MEM_CMD;
                     end
                     CMD_FAST_MATCH : begin
                        fast_saved      <= fast_speed_flag;
                        fast_speed_flag <= 1'b1;  // R24
                        fast_cmd        <= 1'b1;
                        state           <= P_MATCH;
                     end
                     default        : state <= P_IDLE;  // R26
                  endcase
               end
            end
            P_ROM_TX : begin
               if (bit_cnt == ID_LAST_BIT) begin
                  bit_cnt <= '0;
                  state   <= P_MEM_CMD;
               end
            end
            P_MATCH : begin
               if (bit_val != DEVICE_ID[bit_cnt[5:0]]) begin
                  state              <= P_IDLE;  // R14
                  resume_enable_flag <= 1'b0;  // R19
                  if (fast_cmd)
                     fast_speed_flag <= fast_saved;
               end else if (bit_cnt == ID_LAST_BIT) begin
                  bit_cnt            <= '0;
                  state              <= P_MEM_CMD;
                  resume_enable_flag <= 1'b1;  // R18 R24
               end
            end
            P_SRCH_T : begin
               bit_cnt <= bit_cnt;
               state   <= P_SRCH_C;
            end
            P_SRCH_C : begin
               bit_cnt <= bit_cnt;
               state   <= P_SRCH_R;
            end
            P_SRCH_R : begin
               if (bit_val != DEVICE_ID[bit_cnt[5:0]]) begin
                  state              <= P_IDLE;  // R15
                  resume_enable_flag <= 1'b0;  // R19
               end else if (bit_cnt == ID_LAST_BIT) begin
                  bit_cnt            <= '0;
                  state              <= P_MEM_CMD;
                  resume_enable_flag <= 1'b1;  // R18
               end else
                  state <= P_SRCH_T;
            end
            P_MEM_CMD : begin
               shreg <= next_byte;
               if (bit_cnt == 7'd7) begin
                  bit_cnt  <= '0;
                  ext_mode <= (next_byte == CMD_READ_EXT);  // R5
                  state    <= mem_read_start ? P_ADDR : P_IDLE;  // R1 R26
               end
            end
            P_ADDR : begin
               addr_sh <= next_addr;
               if (bit_cnt == 7'd15) begin
                  bit_cnt <= '0;
                  state   <= P_DATA;
               end
            end
            P_DATA  : bit_cnt <= '0;
            default : bit_cnt <= '0;
         endcase
      end
   end

   // Bad-sequence flag: read set wins over scratchpad clear
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst)
         bad_sequence_flag <= 1'b0;
      else if (mem_read_start)
         bad_sequence_flag <= 1'b1;  // R4
      else if (scratch_written)
         bad_sequence_flag <= 1'b0;
   end

   // Copy authorization withheld while bad sequence stands
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst)
         copy_authorized <= 1'b0;
      else
         copy_authorized <= copy_req && !bad_sequence_flag;  // R8
   end

   // CRC16 over command, address and page data, LSB first
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst)
         crc <= '0;
      else if (reset_evt || (state == P_ROM_CMD) ||
               (bit_evt && state == P_DATA && tx_is_crc && tx_left == 5'd1))
         crc <= '0;  // R7
      else if (bit_evt && (state == P_MEM_CMD || state == P_ADDR ||
                           (state == P_DATA && !tx_is_crc && tx_left != 5'd0)))
         crc <= (crc >> 1) ^ ((crc[0] ^ bit_val) ? CRC16_POLY_REV : 16'h0000);  // R7
   end

   // --------------------------------------------------------------
   // Memory, fetch and two-entry buffer
   // --------------------------------------------------------------
   // User-side load port
   always_ff @(posedge sys_clk) begin
      if (mem_wr_en && {4'h0, mem_wr_addr} <= MEM_LAST_ADDR)
         mem[mem_wr_addr] <= mem_wr_data;
   end

   assign push_ready = (fifo_cnt != 2'd2);
   assign push       = (state == P_DATA) && push_ready;
   assign pop        = (state == P_DATA) && (tx_left == 5'd0) && (fifo_cnt != 2'd0);

   // Next item: page CRC marker, fill or memory byte
   always_comb begin
      push_entry.is_crc = crc_pending;  // R5 R6
      if (crc_pending)
         push_entry.data = FILL_BYTE;
      else if (past_end || {4'h0, fetch_addr} > MEM_LAST_ADDR)
         push_entry.data = FILL_BYTE;  // R3 R6
      else
         push_entry.data = mem[fetch_addr];
   end

   // Fetch address walk
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         fetch_addr  <= '0;
         past_end    <= 1'b0;
         crc_pending <= 1'b0;
      end else if (reset_evt) begin
         past_end    <= 1'b0;
         crc_pending <= 1'b0;
      end else if (addr_done) begin
         fetch_addr <= (next_addr > MEM_LAST_ADDR) ? next_addr[11:0] & ADDR_WRAP_MASK[11:0] :
                       next_addr[11:0];  // R2
         past_end   <= 1'b0;
      end else if (push) begin
         if (crc_pending)
            crc_pending <= 1'b0;
         else begin
            fetch_addr  <= fetch_addr + 12'd1;
            past_end    <= past_end || ({4'h0, fetch_addr} >= MEM_LAST_ADDR);
            crc_pending <= ext_mode && (fetch_addr[4:0] == PAGE_LAST_OFS);  // R5
         end
      end
   end

   // Two-entry buffer storage and pointers
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         wr_ptr   <= 1'b0;
         rd_ptr   <= 1'b0;
         fifo_cnt <= '0;
         fifo[0]  <= '0;
         fifo[1]  <= '0;
      end else if (reset_evt) begin
         wr_ptr   <= 1'b0;
         rd_ptr   <= 1'b0;
         fifo_cnt <= '0;
      end else begin
         if (push) begin
            fifo[wr_ptr] <= push_entry;
            wr_ptr       <= ~wr_ptr;
         end
         if (pop)
            rd_ptr <= ~rd_ptr;
         fifo_cnt <= fifo_cnt + {1'b0, push} - {1'b0, pop};
      end
   end

   // Line shifter: data LSB first, inverted CRC after page
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         tx_sh     <= '1;
         tx_left   <= '0;
         tx_is_crc <= 1'b0;
      end else if (reset_evt || state != P_DATA) begin
         tx_left   <= '0;
         tx_is_crc <= 1'b0;
      end else if (pop) begin
         tx_is_crc <= fifo[rd_ptr].is_crc;
         tx_sh     <= fifo[rd_ptr].is_crc ? ~crc : {8'hFF, fifo[rd_ptr].data};  // R5
         tx_left   <= fifo[rd_ptr].is_crc ? 5'd16 : 5'd8;
      end else if (bit_evt && tx_left != 5'd0) begin
         tx_sh   <= {1'b1, tx_sh[15:1]};  // R25
         tx_left <= tx_left - 5'd1;
      end
   end

   // --------------------------------------------------------------
   // Checks
   // --------------------------------------------------------------
   sequence s_rom_cmd(logic [7:0] code);
      rom_done && next_byte == code;
   endsequence
   sequence s_mem_cmd(logic [7:0] code);
      mem_done && next_byte == code;
   endsequence

   a_skip_to_mem: assert property (@(posedge sys_clk) disable iff (sys_rst)  // R16
      s_rom_cmd(CMD_SKIP_ID) |=> state == P_MEM_CMD)
      else $error("skip did not reach memory commands");
   a_resume_gate: assert property (@(posedge sys_clk) disable iff (sys_rst)  // R17
      s_rom_cmd(CMD_RESUME) ##0 !resume_enable_flag |=> state == P_IDLE)
      else $error("resume answered without flag");
   a_fast_skip: assert property (@(posedge sys_clk) disable iff (sys_rst)  // R20
      s_rom_cmd(CMD_FAST_SKIP) |=> fast_speed_flag && state == P_MEM_CMD)
      else $error("fast skip did not set speed");
   a_match_drop: assert property (@(posedge sys_clk) disable iff (sys_rst)  // R14
      bit_evt && state == P_MATCH && bit_val != DEVICE_ID[bit_cnt[5:0]] && !reset_evt
      |=> state == P_IDLE && !resume_enable_flag)
      else $error("mismatch did not deselect");
   a_read_sets_bs: assert property (@(posedge sys_clk) disable iff (sys_rst)  // R4
      (s_mem_cmd(CMD_READ_MEM) or s_mem_cmd(CMD_READ_EXT)) ##0 !reset_evt
      |=> bad_sequence_flag && state == P_ADDR)
      else $error("memory read left flag clear");
   a_copy_blocked: assert property (@(posedge sys_clk) disable iff (sys_rst)  // R8
      bad_sequence_flag |=> !copy_authorized)
      else $error("copy authorized during bad sequence");
   a_addr_wrap: assert property (@(posedge sys_clk) disable iff (sys_rst)  // R2
      addr_done && !reset_evt && next_addr > MEM_LAST_ADDR
      |=> fetch_addr == ($past(next_addr[11:0]) & ADDR_WRAP_MASK[11:0]) && state == P_DATA)
      else $error("target address not wrapped");
   a_fill_past_end: assert property (@(posedge sys_clk) disable iff (sys_rst)  // R3
      push && !crc_pending && past_end |-> push_entry.data == FILL_BYTE)
      else $error("data past end not filled");
   a_page_crc: assert property (@(posedge sys_clk) disable iff (sys_rst)  // R5
      push && !reset_evt && ext_mode && !crc_pending && fetch_addr[4:0] == PAGE_LAST_OFS
      |=> crc_pending)
      else $error("page end without crc");
endmodule // swire_eeprom_cmd

// file: bench/line_master.sv
/* Far-side master model: reset, write and read slots.
   Assumes sys_clk of the design and a pulled-up line. */
`timescale 1ns/1ps
module line_master (
   input  wire logic sys_clk,
   input  wire logic dq_out,
   input  wire logic dq_oe_n,
   output logic      dq_line
);
   logic m_low = 1'b0;
   // Wired-AND with pull-up
   assign dq_line = ~m_low & (dq_oe_n | dq_out);
   // Low for n cycles, idle high for r
   task automatic pulse(input int n, input int r);
      m_low = 1'b1;
      repeat (n) @(negedge sys_clk);
      m_low = 1'b0;
      repeat (r) @(negedge sys_clk);
   endtask
   // Long reset, then look for presence
   task automatic bus_reset(output logic pres);
      pres = 1'b0;
      pulse(450, 0);
      repeat (4000) begin
         @(negedge sys_clk);
         if (dq_line === 1'b0) pres = 1'b1;
      end
   endtask
   task automatic wr_byte(input logic [7:0] b);
      for (int i = 0; i < 8; i++) pulse(b[i] ? 5 : 50, b[i] ? 55 : 10);
   endtask
   task automatic rd_bit(output logic v);
      pulse(2, 18);
      v = dq_line;
      repeat (40) @(negedge sys_clk);
   endtask
endmodule // line_master

// file: bench/single_wire_eeprom_command_layer_tb.sv
/* Self-checking bench for the command layer.
   Assumes line_master as the far side of the line. */
`timescale 1ns/1ps
module single_wire_eeprom_command_layer_tb;
   import swire_pkg::*;
   localparam logic [63:0] ID = 64'h1D2C_3B4A_5968_7786;  // Arbitrary value
   logic sys_clk = 1'b0, sys_rst = 1'b1, we = 1'b0, sw = 1'b0, cq = 1'b0;
   logic [11:0] wa = 12'h000;
   logic [7:0]  wd = 8'h00;
   logic        dq_line, dq_out, dq_oe_n, ca, bsf, rsf, fsf;
   int          n_errors = 0, cmp_count = 0;
   line_master m (.sys_clk(sys_clk), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .dq_line(dq_line));
   swire_eeprom_cmd #(.DEVICE_ID(ID), .SAMPLE_STD_CYC(40), .RST_STD_CYC(200), .RST_LONG_CYC(400),
      .PDL_STD_CYC(60)) uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .dq_in(dq_line), .dq_out(dq_out),
      .dq_oe_n(dq_oe_n), .mem_wr_en(we), .mem_wr_addr(wa), .mem_wr_data(wd), .scratch_written(sw),
      .copy_req(cq), .copy_authorized(ca), .bad_sequence_flag(bsf), .resume_enable_flag(rsf),
      .fast_speed_flag(fsf));
   always #2 sys_clk = ~sys_clk;
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      cmp_count++;
      if (g !== e) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic rst_seq();
      logic p;
      m.bus_reset(p);
      chk({15'h0000, p}, 16'h0001);
   endtask
   task automatic rd_byte(output logic [7:0] b);
      logic v;
      for (int i = 0; i < 8; i++) begin
         m.rd_bit(v);
         b[i] = v;
      end
   endtask
   function automatic logic [15:0] crc(input logic [15:0] c, input logic [7:0] b);
      for (int i = 0; i < 8; i++) c = (c[0] ^ b[i]) ? ((c >> 1) ^ CRC16_POLY_REV) : (c >> 1);
      return c;
   endfunction
   task automatic t_read_id();
      logic [7:0] b;
      rst_seq();
      m.wr_byte(CMD_READ_ID);
      for (int k = 0; k < 8; k++) begin
         rd_byte(b);
         chk({8'h00, b}, {8'h00, ID[8*k+:8]});
      end
   endtask
   task automatic t_fast();
      rst_seq();
      m.wr_byte(CMD_FAST_SKIP);
      chk({15'h0000, fsf}, 16'h0001);
      rst_seq();
      chk({15'h0000, fsf}, 16'h0000);
   endtask
   task automatic t_plain();
      logic [7:0] b;
      rst_seq();
      m.wr_byte(CMD_SKIP_ID);
      m.wr_byte(CMD_READ_MEM);
      chk({15'h0000, bsf}, 16'h0001);
      m.wr_byte(8'h3E);
      m.wr_byte(8'h0A);
      for (int k = 0; k < 3; k++) begin
         rd_byte(b);
         chk({8'h00, b}, (k < 2) ? {8'h00, 8'h02 ^ k[7:0]} : 16'h00FF);
      end
      for (int k = 0; k < 2; k++) begin
         cq = 1'b1;
         @(negedge sys_clk);
         cq = 1'b0;
         chk({15'h0000, ca}, {15'h0000, k[0]});
         @(negedge sys_clk);
         sw = 1'b1;
         @(negedge sys_clk);
         sw = 1'b0;
      end
   endtask
   task automatic t_ext();
      logic [7:0] b;
      logic [15:0] c;
      rst_seq();
      m.wr_byte(CMD_MATCH_ID);
      for (int k = 0; k < 8; k++) m.wr_byte(ID[8*k+:8]);
      chk({15'h0000, rsf}, 16'h0001);
      rst_seq();
      m.wr_byte(CMD_RESUME);
      m.wr_byte(CMD_READ_EXT);
      m.wr_byte(8'h20);
      m.wr_byte(8'hFA);
      c = crc(crc(crc(16'h0000, 8'hA5), 8'h20), 8'hFA);
      for (int k = 0; k < 32; k++) begin
         rd_byte(b);
         chk({8'h00, b}, {8'h00, k[7:0] ^ 8'h1C});
         c = crc(c, k[7:0] ^ 8'h1C);
      end
      rd_byte(b);
      chk({8'h00, b}, {8'h00, ~c[7:0]});
      rd_byte(b);
      chk({8'h00, b}, {8'h00, ~c[15:8]});
      rd_byte(b);
      chk({8'h00, b}, 16'h00FF);
      rst_seq();
      m.wr_byte(CMD_MATCH_ID);
      for (int k = 0; k < 8; k++) m.wr_byte(~ID[8*k+:8]);
      chk({15'h0000, rsf}, 16'h0000);
      sw = 1'b1;
      @(negedge sys_clk);
      sw = 1'b0;
      rst_seq();
      m.wr_byte(CMD_RESUME);
      m.wr_byte(CMD_READ_MEM);
      chk({15'h0000, bsf}, 16'h0000);
   endtask
   task automatic t_search();
      logic t, c;
      rst_seq();
      m.wr_byte(CMD_SEARCH_ID);
      for (int i = 0; i < 64; i++) begin
         m.rd_bit(t);
         m.rd_bit(c);
         chk({14'h0000, t, c}, {14'h0000, ID[i], ~ID[i]});
         m.pulse(ID[i] ? 5 : 50, ID[i] ? 55 : 10);
      end
      chk({15'h0000, rsf}, 16'h0001);
   endtask
   task automatic give_verdict();
      if (n_errors == 0 && cmp_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (3) @(negedge sys_clk);
      sys_rst = 1'b0;
      for (int a = 12'hA00; a < 12'hA40; a++) begin
         we = 1'b1;
         wa = a[11:0];
         wd = a[7:0] ^ 8'h3C;
         @(negedge sys_clk);
      end
      we = 1'b0;
      t_read_id();
      t_fast();
      t_plain();
      t_ext();
      t_search();
      give_verdict();
   end
   // Watchdog
   initial begin
      #480000;
      n_errors++;
      give_verdict();
   end
endmodule // single_wire_eeprom_command_layer_tb
